// ==== hw/bcac_regs.svh ====
// Register offsets, field positions, reset values and write masks of the bridge configuration bank.
// Included by the bank module; definitions only.
`ifndef BCAC_REGS_SVH
`define BCAC_REGS_SVH

`define BCAC_ADDR_STATUS        8'h50
`define BCAC_ADDR_BRIDGE        8'h54
`define BCAC_ADDR_AUDIO         8'h55

`define BCAC_BR_EXTERNAL_CONTROL_SELECT         7
`define BCAC_BR_RX_INT_EN       6
`define BCAC_BR_EDID_DIS        5
`define BCAC_BR_INIT_DIS        4
`define BCAC_BR_PROT_DIS        3
`define BCAC_BR_AUDIO_TDM       2
`define BCAC_BR_AUDIO_LOCAL     1
`define BCAC_BR_AUX_EN          0

`define BCAC_AU_TDM_PAR         7
`define BCAC_AU_RX_I2S_OUT      6
`define BCAC_AU_RST_ON_TYPE     3

`define BCAC_ST_RX_INT          6

`define BCAC_BRIDGE_RESET       8'h00
`define BCAC_AUDIO_RESET        8'h0c
`define BCAC_AUDIO_WMASK        8'hcf

`endif

// ==== hw/bcac_pkg.sv ====
// Types of the bridge configuration bank.
// Needs nothing else.
package bcac_pkg;

    typedef enum logic [5:0] {
        ST_STRAP     = 6'h01,
        ST_EDID      = 6'h02,
        ST_INIT      = 6'h04,
        ST_INIT_WAIT = 6'h08,
        ST_PROT      = 6'h10,
        ST_DONE      = 6'h20
    } bcac_state_t;

endpackage : bcac_pkg

// ==== hw/bcac_top.sv ====
// Bridge control and audio configuration bank with its start-up sequencer.
// Assumes a register port already decoded from the serial control bus, and synchronous inputs.
//
// Contract
// - When external control is set the bank starts neither receiver initialisation nor protection setup.
// - With the receiver interrupt enable set, a pending receiver interrupt drives the interrupt pin low.
// - The remote EDID load is started at start-up unless its disable bit is set.
// - External control and remote EDID disable load their start-up value from the second strap pin.
// - The receiver is initialised automatically unless the init disable bit is set.
// - Protection control defaults are programmed unless the protection setup disable bit is set.
// - The audio source bit selects received audio at 0 and local I2S audio at 1.
// - The TDM bit enables TDM-to-parallel conversion for downstream audio.
// - Received audio goes out on the I2S pins only when enabled and received audio is selected.
// - With reset-on-type set, an audio type change resets the received audio FIFO.
// - Status bit 6 reads 1 while a receiver interrupt is pending.
`timescale 1ns/10ps
`include "bcac_regs.svh"

module bcac_top (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       strap_pin_first,
    input  wire logic       strap_pin_second,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       rx_irq_pending,
    input  wire logic       rx_init_done,
    input  wire logic       audio_type_changed,
    output logic            interrupt_out_n,
    output logic            remote_edid_load_start,
    output logic            rx_init_start,
    output logic            protect_setup_start,
    output logic            external_control_select,
    output logic            audio_source_local,
    output logic            aux_audio_enable,
    output logic            tdm_convert_enable,
    output logic            rx_i2s_out_enable,
    output logic            audio_fifo_reset
);

    logic [7:0]           bridge_settings;
    logic [7:0]           audio_settings;
    bcac_pkg::bcac_state_t state;
    bcac_pkg::bcac_state_t next_state;
    logic                 ext;

    assign ext = bridge_settings[`BCAC_BR_EXTERNAL_CONTROL_SELECT];

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bridge_settings <= `BCAC_BRIDGE_RESET;
        end else if (state == bcac_pkg::ST_STRAP) begin
            bridge_settings[`BCAC_BR_EXTERNAL_CONTROL_SELECT]  <= strap_pin_second;
            bridge_settings[`BCAC_BR_EDID_DIS] <= strap_pin_second;
            bridge_settings[`BCAC_BR_AUX_EN]   <= strap_pin_first;
        end else if (reg_wr && reg_addr == `BCAC_ADDR_BRIDGE) begin
            bridge_settings <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            audio_settings <= `BCAC_AUDIO_RESET;
        end else if (reg_wr && reg_addr == `BCAC_ADDR_AUDIO) begin
            audio_settings <= reg_wdata & `BCAC_AUDIO_WMASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `BCAC_ADDR_STATUS: reg_rdata <= {1'b0, rx_irq_pending, 6'h00};
                `BCAC_ADDR_BRIDGE: reg_rdata <= bridge_settings;
                `BCAC_ADDR_AUDIO:  reg_rdata <= audio_settings;
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            bcac_pkg::ST_STRAP:     next_state = bcac_pkg::ST_EDID;
            bcac_pkg::ST_EDID:      next_state = bcac_pkg::ST_INIT;
            bcac_pkg::ST_INIT: begin
                if (ext) begin
                    next_state = bcac_pkg::ST_DONE;
                end else if (!bridge_settings[`BCAC_BR_INIT_DIS]) begin
                    next_state = bcac_pkg::ST_INIT_WAIT;
                end else begin
                    next_state = bcac_pkg::ST_PROT;
                end
            end
            bcac_pkg::ST_INIT_WAIT: begin
                if (ext) begin
                    next_state = bcac_pkg::ST_DONE;
                end else if (rx_init_done) begin
                    next_state = bcac_pkg::ST_PROT;
                end
            end
            bcac_pkg::ST_PROT:      next_state = bcac_pkg::ST_DONE;
            bcac_pkg::ST_DONE:      next_state = bcac_pkg::ST_DONE;
            default:                next_state = bcac_pkg::ST_STRAP;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= bcac_pkg::ST_STRAP;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            remote_edid_load_start <= 1'b0;
            rx_init_start          <= 1'b0;
            protect_setup_start    <= 1'b0;
        end else begin
            remote_edid_load_start <= (state == bcac_pkg::ST_EDID) && !bridge_settings[`BCAC_BR_EDID_DIS];
            rx_init_start          <= (state == bcac_pkg::ST_INIT) && !ext
                                      && !bridge_settings[`BCAC_BR_INIT_DIS];
            protect_setup_start    <= (state == bcac_pkg::ST_PROT) && !ext
                                      && !bridge_settings[`BCAC_BR_PROT_DIS];
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin and audio controls
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= !(bridge_settings[`BCAC_BR_RX_INT_EN] && rx_irq_pending);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            external_control_select <= 1'b0;
            audio_source_local      <= 1'b0;
            aux_audio_enable        <= 1'b0;
            tdm_convert_enable      <= 1'b0;
            rx_i2s_out_enable       <= 1'b0;
            audio_fifo_reset        <= 1'b0;
        end else begin
            external_control_select <= ext;
            audio_source_local      <= bridge_settings[`BCAC_BR_AUDIO_LOCAL];
            aux_audio_enable        <= bridge_settings[`BCAC_BR_AUX_EN];
            tdm_convert_enable      <= audio_settings[`BCAC_AU_TDM_PAR];
            rx_i2s_out_enable       <= audio_settings[`BCAC_AU_RX_I2S_OUT]
                                       && !bridge_settings[`BCAC_BR_AUDIO_LOCAL];
            audio_fifo_reset        <= audio_settings[`BCAC_AU_RST_ON_TYPE] && audio_type_changed;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_init_go;
        state == bcac_pkg::ST_INIT && !ext && !bridge_settings[`BCAC_BR_INIT_DIS];
    endsequence

    sequence s_init_started;
        rx_init_start && state == bcac_pkg::ST_INIT_WAIT;
    endsequence

    AST_EXT_BLOCKS_INIT: assert property (@(posedge clk) disable iff (!arst_n)
        rx_init_start |-> !$past(ext)) else $error("Init started under external control");
    AST_INT_PIN: assert property (@(posedge clk) disable iff (!arst_n)
        (bridge_settings[`BCAC_BR_RX_INT_EN] && rx_irq_pending) |=> !interrupt_out_n)
        else $error("Interrupt pin not asserted");
    AST_INT_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
        !bridge_settings[`BCAC_BR_RX_INT_EN] |=> interrupt_out_n) else $error("Interrupt pin asserted while disabled");
    AST_EDID_SKIP: assert property (@(posedge clk) disable iff (!arst_n)
        remote_edid_load_start |-> !$past(bridge_settings[`BCAC_BR_EDID_DIS])) else $error("EDID load not skipped");
    // Sampled reset in the antecedent keeps the release edge, where the flops are still held, out of the check
    AST_STRAP_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && state == bcac_pkg::ST_STRAP |=> ext == $past(strap_pin_second)
            && bridge_settings[`BCAC_BR_EDID_DIS] == $past(strap_pin_second)
            && bridge_settings[`BCAC_BR_AUX_EN] == $past(strap_pin_first)) else $error("Strap value not loaded");
    AST_INIT_SEQ: assert property (@(posedge clk) disable iff (!arst_n)
        s_init_go |=> s_init_started) else $error("Receiver init not started");
    AST_PROT_SKIP: assert property (@(posedge clk) disable iff (!arst_n)
        protect_setup_start |-> $past(!bridge_settings[`BCAC_BR_PROT_DIS] && !ext))
        else $error("Protect setup not skipped");
    AST_AUDIO_SRC: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> audio_source_local == $past(bridge_settings[`BCAC_BR_AUDIO_LOCAL]))
        else $error("Audio source mismatch");
    AST_TDM: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(audio_settings[`BCAC_AU_TDM_PAR]) |=> tdm_convert_enable) else $error("TDM conversion not enabled");
    AST_I2S_OUT: assert property (@(posedge clk) disable iff (!arst_n)
        rx_i2s_out_enable |-> !$past(bridge_settings[`BCAC_BR_AUDIO_LOCAL])) else $error("I2S out with local audio");
    AST_FIFO_RST: assert property (@(posedge clk) disable iff (!arst_n)
        audio_fifo_reset |-> $past(audio_type_changed && audio_settings[`BCAC_AU_RST_ON_TYPE]))
        else $error("Unexpected audio FIFO reset");
    AST_STATUS_RD: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == `BCAC_ADDR_STATUS) |=> reg_rdata[`BCAC_ST_RX_INT] == $past(rx_irq_pending))
        else $error("Status interrupt bit wrong");
    AST_RSVD: assert property (@(posedge clk) disable iff (!arst_n)
        audio_settings[5:4] == 2'b00) else $error("Reserved audio bits set");
    AST_PROT_GO: assert property (@(posedge clk) disable iff (!arst_n)
        (state == bcac_pkg::ST_PROT && !ext && !bridge_settings[`BCAC_BR_PROT_DIS]) |=> protect_setup_start)
        else $error("Protect setup not started");
    AST_AUX_EN: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> aux_audio_enable == $past(bridge_settings[`BCAC_BR_AUX_EN]))
        else $error("Aux audio enable mismatch");
    AST_I2S_GO: assert property (@(posedge clk) disable iff (!arst_n)
        (audio_settings[`BCAC_AU_RX_I2S_OUT] && !bridge_settings[`BCAC_BR_AUDIO_LOCAL]) |=> rx_i2s_out_enable)
        else $error("I2S out not enabled");
    AST_FIFO_RST_GO: assert property (@(posedge clk) disable iff (!arst_n)
        (audio_type_changed && audio_settings[`BCAC_AU_RST_ON_TYPE]) |=> audio_fifo_reset)
        else $error("Audio FIFO reset missing");

endmodule : bcac_top

// ==== verif/bcac_host_model.sv ====
// Host-side stand-in that finishes receiver setup some cycles after a start request.
// Assumes the clock and reset of the configuration bank.
`timescale 1ns/10ps
module bcac_host_model #(
    parameter int DELAY = 3
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic rx_init_start,
    output logic      rx_init_done
);
    int cnt;
    // One-cycle done pulse DELAY+1 cycles after the start pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt          <= 0;
            rx_init_done <= 1'b0;
        end else begin
            rx_init_done <= (cnt == 1);
            if (rx_init_start)
                cnt <= DELAY;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule : bcac_host_model

// ==== verif/test_bridge_control_audio_config.sv ====
// Self-checking bench of the bridge configuration bank.
// Assumes the host model stands in for receiver setup.
`timescale 1ns/10ps
module test_bridge_control_audio_config;
    logic       clk = 1'b0, arst_n = 1'b0, s1 = 1'b1, s2 = 1'b1, wr = 1'b0, rd = 1'b0;
    logic       irq = 1'b0, atc = 1'b0, done, int_n, edid, init, prot, ext, src, aux, tdm, i2s, fifo;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
    int         fails = 0, num_checks = 0, edid_n, init_n, prot_n, fifo_n;
    logic [31:0] rows [6] = '{32'h54020208, 32'h54818114, 32'h55ffcf17, 32'h5402020a, 32'h56ff000a,
                              32'h55000008};
    always #5 clk = ~clk;
    bcac_top u_dut (.clk(clk), .arst_n(arst_n), .strap_pin_first(s1), .strap_pin_second(s2),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .rx_irq_pending(irq), .rx_init_done(done), .audio_type_changed(atc), .interrupt_out_n(int_n),
        .remote_edid_load_start(edid), .rx_init_start(init), .protect_setup_start(prot),
        .external_control_select(ext), .audio_source_local(src), .aux_audio_enable(aux),
        .tdm_convert_enable(tdm), .rx_i2s_out_enable(i2s), .audio_fifo_reset(fifo));
    bcac_host_model #(.DELAY(4)) u_host (.clk(clk), .arst_n(arst_n), .rx_init_start(init), .rx_init_done(done));
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            edid_n <= 0;
            init_n <= 0;
            prot_n <= 0;
            fifo_n <= 0;
        end else begin
            edid_n <= edid_n + int'(edid === 1'b1);
            init_n <= init_n + int'(init === 1'b1);
            prot_n <= prot_n + int'(prot === 1'b1);
            fifo_n <= fifo_n + int'(fifo === 1'b1);
        end
    end
    task automatic give_verdict;
        $display("Checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic do_reset;
        @(posedge clk) arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) wr <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk) wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk) rd <= 1'b1;
        addr <= a;
        @(posedge clk) rd <= 1'b0;
        #1 got = rdata;
    endtask : reg_read
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic type_pulse;
        @(posedge clk) atc <= 1'b1;
        @(posedge clk) atc <= 1'b0;
        settle(3);
    endtask : type_pulse
    initial begin
        do_reset();
        reg_read(8'h54);
        chk(got, 8'ha1);
        reg_read(8'h55);
        chk(got, 8'h0c);
        settle(20);
        chk(8'(edid_n + init_n + prot_n), 8'h00);
        foreach (rows[i]) begin
            reg_write(rows[i][31:24], rows[i][23:16]);
            settle(2);
            chk({3'b000, ext, src, aux, tdm, i2s}, rows[i][7:0]);
            reg_read(rows[i][31:24]);
            chk(got, rows[i][15:8]);
        end
        @(posedge clk) irq <= 1'b1;
        reg_write(8'h54, 8'h40);
        settle(2);
        chk({7'h00, int_n}, 8'h00);
        reg_read(8'h50);
        chk(got, 8'h40);
        reg_write(8'h54, 8'h00);
        settle(2);
        chk({7'h00, int_n}, 8'h01);
        @(posedge clk) irq <= 1'b0;
        reg_write(8'h55, 8'h08);
        type_pulse();
        chk(8'(fifo_n), 8'h01);
        reg_write(8'h55, 8'h00);
        type_pulse();
        chk(8'(fifo_n), 8'h01);
        @(posedge clk) s1 <= 1'b0;
        s2 <= 1'b0;
        do_reset();
        for (int i = 0; i < 50 && prot_n == 0; i++)
            @(posedge clk);
        if (prot_n == 0) begin
            chk(8'(prot_n), 8'h01);
            give_verdict();
        end
        settle(2);
        chk({2'b00, 3'(edid_n), 3'(init_n)}, 8'h09);
        chk({ext, aux, 6'(prot_n)}, 8'h01);
        // Writes land while the sequencer waits for init done: external control, then protect disable
        for (int k = 0; k < 2; k++) begin
            do_reset();
            reg_write(8'h54, (k == 0) ? 8'h80 : 8'h08);
            settle(20);
            chk({2'b00, 3'(edid_n), 3'(init_n)}, 8'h09);
            chk(8'(prot_n), 8'h00);
        end
        give_verdict();
    end
endmodule : test_bridge_control_audio_config
